// *** rtl/ioacc_core.sv ***
// Command interpreter for input reads, accumulator arithmetic and compare.
// Assumes host bytes and program instructions synchronous to i_clk.
//
// Overview of operation
// - Read-input code 15, port, bank 0-2
// - Digital reads 0/1, analog 0 to 4095
// - Stored-program read copies value into accumulator
// - Direct read replies only, accumulator kept
// - Read reply status 100 with port state
// - Reply: host, target, status, code, value, sum
// - Bank 0 ports 0-3 give input bits
// - Port 255 bank 0 gives all inputs
// - Analog line readable in analog bank only
// - Bank 1 port 0 gives analog sample
// - Bank 1 port 8 gives supply voltage
// - Bank 2 ports 0-1 give output states
// - Arithmetic code 19, operand in value
// - Type selects one of ten operations
// - Arithmetic result written to accumulator
// - Direct arithmetic replies 100 with operand
// - Compare code 20 against value operand
// - Compare updates arithmetic status flags
// - Jump conditions zero through lower-or-equal
`timescale 1ns/1ps
`default_nettype none
module ioacc_core
    import ioacc_pkg::*;
(
    input  wire logic                    i_clk,
    input  wire logic                    i_rstn,
    input  wire logic                    i_rx_valid,
    input  wire logic [7:0]              i_rx_byte,
    output var  logic                    o_rx_ready,
    output var  logic                    o_tx_valid,
    output var  logic [7:0]              o_tx_byte,
    input  wire logic                    i_tx_ready,
    input  wire logic                    i_prog_valid,
    input  wire ioacc_pkg::ioacc_cmd_type i_prog_cmd,
    output var  logic                    o_prog_ack,
    input  wire logic [3:0]              i_gen_in,
    input  wire logic [11:0]             i_adc_in0,
    input  wire logic [15:0]             i_supply_dv,
    input  wire logic [1:0]              i_out_state,
    input  wire logic [2:0]              i_cond_sel,
    output var  logic                    o_cond_met,
    output var  logic signed [31:0]      o_acc,
    output var  ioacc_pkg::ioacc_flags_type o_flags
);
    import ioacc_pkg::*;

    typedef enum logic {ST_RECEIVE, ST_REPLY} ioacc_state_type;

    // ****************************************
    // Receive side
    // ****************************************
    logic [7:0]      rx_buf [0:7];
    logic [7:0]      next_rx_buf [0:7];
    logic [3:0]      rx_cnt;
    logic [3:0]      next_rx_cnt;
    logic [7:0]      rx_sum;
    logic            rx_take;
    logic            rx_last;
    logic            frame_ok;
    ioacc_cmd_type   host_cmd;

    always_comb begin
        rx_sum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            rx_sum = rx_sum + rx_buf[i];
        end
        rx_take  = i_rx_valid && o_rx_ready;
        rx_last  = rx_take && (rx_cnt == LAST_IDX);
        frame_ok = rx_last && (rx_sum == i_rx_byte)
                   && (rx_buf[0] == MODULE_ADDR);
        host_cmd = {rx_buf[1], rx_buf[2], rx_buf[3],
                    rx_buf[4], rx_buf[5], rx_buf[6], rx_buf[7]};
        next_rx_buf = rx_buf;
        next_rx_cnt = rx_cnt;
        if (rx_take) begin
            if (rx_last) begin
                next_rx_cnt = 4'h0;
            end else begin
                next_rx_buf[rx_cnt[2:0]] = i_rx_byte;
                next_rx_cnt = rx_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_cnt <= 4'h0;
            for (int i = 0; i < 8; i++) begin
                rx_buf[i] <= 8'h00;
            end
        end else begin
            rx_cnt <= next_rx_cnt;
            rx_buf <= next_rx_buf;
        end
    end

    // ****************************************
    // Execution
    // ****************************************
    ioacc_state_type state;
    ioacc_state_type next_state;
    logic            prog_take;
    logic            exec_go;
    logic            exec_stored;
    ioacc_cmd_type   cmd;
    logic [31:0]     rd_value;
    logic signed [31:0] arith;
    logic signed [31:0] next_acc;
    ioacc_flags_type next_flags;
    logic [7:0]      status;
    logic [31:0]     rep_value;
    logic            next_cond_met;
    logic            next_prog_ack;

    always_comb begin
        prog_take   = i_prog_valid && (state == ST_RECEIVE) && !rx_last;
        exec_go     = frame_ok || prog_take;
        exec_stored = !frame_ok;
        cmd         = frame_ok ? host_cmd : i_prog_cmd;
        rd_value    = 32'h0;
        case (cmd.bank)
            BANK_DIGITAL: begin
                if (cmd.sel == PORT_ALL) begin
                    rd_value = {28'h0, i_gen_in};
                end else if (cmd.sel <= PORT_LAST_IN) begin
                    rd_value = {31'h0, i_gen_in[cmd.sel[1:0]]};
                end
            end
            BANK_ANALOG: begin
                if (cmd.sel == 8'h00) begin
                    rd_value = {20'h0, i_adc_in0};
                end else if (cmd.sel == PORT_SUPPLY) begin
                    rd_value = {16'h0, i_supply_dv};
                end
            end
            BANK_OUTPUTS: begin
                if (cmd.sel <= PORT_LAST_OUT) begin
                    rd_value = {31'h0, i_out_state[cmd.sel[0]]};
                end
            end
            default: rd_value = 32'h0;
        endcase
        arith = o_acc;
        case (cmd.sel)
            AR_ADD:  arith = o_acc + cmd.value;
            AR_SUB:  arith = o_acc - cmd.value;
            AR_MUL:  arith = o_acc * cmd.value;
            AR_DIV:  arith = (cmd.value == 0) ? o_acc : o_acc / cmd.value;
            AR_MODULO: arith = (cmd.value == 0) ? o_acc : o_acc % cmd.value;
            AR_AND:  arith = o_acc & cmd.value;
            AR_OR:   arith = o_acc | cmd.value;
            AR_XOR:  arith = o_acc ^ cmd.value;
            AR_NOT:  arith = ~o_acc;
            AR_LOAD: arith = cmd.value;
            default: arith = o_acc;
        endcase
        next_acc   = o_acc;
        next_flags = o_flags;
        status     = STATUS_OK;
        rep_value  = cmd.value;
        if (exec_go) begin
            case (cmd.opcode)
                OP_READ_IO: begin
                    rep_value = rd_value;
                    if (exec_stored) begin
                        next_acc = rd_value;
                    end
                end
                OP_ARITH: begin
                    if (cmd.sel > AR_LOAD) begin
                        status = STATUS_BAD_CMD;
                    end
                    next_acc = arith;
                end
                OP_COMPARE: begin
                    next_flags.zero    = (o_acc == cmd.value);
                    next_flags.equal   = (o_acc == cmd.value);
                    next_flags.greater = (o_acc > cmd.value);
                    next_flags.lower   = (o_acc < cmd.value);
                end
                default: status = STATUS_BAD_CMD;
            endcase
        end
        case (i_cond_sel)
            CND_ZE: next_cond_met = o_flags.zero;
            CND_NZ: next_cond_met = !o_flags.zero;
            CND_EQ: next_cond_met = o_flags.equal;
            CND_NE: next_cond_met = !o_flags.equal;
            CND_GT: next_cond_met = o_flags.greater;
            CND_GE: next_cond_met = o_flags.greater || o_flags.equal;
            CND_LT: next_cond_met = o_flags.lower;
            CND_LE: next_cond_met = o_flags.lower || o_flags.equal;
            default: next_cond_met = 1'b0;
        endcase
        next_prog_ack = prog_take;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_acc      <= ACC_RESET;
            o_flags    <= '0;
            o_cond_met <= 1'b0;
            o_prog_ack <= 1'b0;
        end else begin
            o_acc      <= next_acc;
            o_flags    <= next_flags;
            o_cond_met <= next_cond_met;
            o_prog_ack <= next_prog_ack;
        end
    end

    // ****************************************
    // Reply side
    // ****************************************
    logic [7:0]      tx_buf [0:8];
    logic [7:0]      next_tx_buf [0:8];
    logic [3:0]      tx_cnt;
    logic [3:0]      next_tx_cnt;
    logic [7:0]      tx_sum;
    logic            next_rx_ready;
    logic            next_tx_valid;

    always_comb begin
        next_tx_buf = tx_buf;
        next_tx_cnt = tx_cnt;
        next_state  = state;
        next_tx_buf[0] = HOST_ADDR;
        next_tx_buf[1] = MODULE_ADDR;
        next_tx_buf[2] = status;
        next_tx_buf[3] = cmd.opcode;
        next_tx_buf[4] = rep_value[31:24];
        next_tx_buf[5] = rep_value[23:16];
        next_tx_buf[6] = rep_value[15:8];
        next_tx_buf[7] = rep_value[7:0];
        tx_sum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            tx_sum = tx_sum + next_tx_buf[i];
        end
        next_tx_buf[8] = tx_sum;
        if (state == ST_RECEIVE) begin
            if (!frame_ok) begin
                next_tx_buf = tx_buf;
            end else begin
                next_tx_cnt = 4'h0;
                next_state  = ST_REPLY;
            end
        end else begin
            next_tx_buf = tx_buf;
            if (i_tx_ready) begin
                for (int i = 0; i < 8; i++) begin
                    next_tx_buf[i] = tx_buf[i + 1];
                end
                next_tx_cnt = tx_cnt + 4'h1;
                if (tx_cnt == LAST_IDX) begin
                    next_state = ST_RECEIVE;
                end
            end
        end
        next_rx_ready = (next_state == ST_RECEIVE);
        next_tx_valid = (next_state == ST_REPLY);
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state      <= ST_RECEIVE;
            tx_cnt     <= 4'h0;
            o_rx_ready <= 1'b1;
            o_tx_valid <= 1'b0;
            for (int i = 0; i < 9; i++) begin
                tx_buf[i] <= 8'h00;
            end
        end else begin
            state      <= next_state;
            tx_cnt     <= next_tx_cnt;
            o_rx_ready <= next_rx_ready;
            o_tx_valid <= next_tx_valid;
            tx_buf     <= next_tx_buf;
        end
    end

    assign o_tx_byte = tx_buf[0];

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence seq_host_read;
        frame_ok && (cmd.opcode == OP_READ_IO);
    endsequence

    sequence seq_prog_op(logic [7:0] op);
        prog_take && (i_prog_cmd.opcode == op);
    endsequence

    sequence seq_reply_start;
        !o_tx_valid ##1 o_tx_valid;
    endsequence

    chk_direct_read_keep: assert property (
        seq_host_read |=> $stable(o_acc))
        else $error("direct read changed accumulator");

    chk_stored_read_acc: assert property (
        seq_prog_op(OP_READ_IO) |=> (o_acc == $past(rd_value)))
        else $error("stored read not copied");

    chk_read_status_ok: assert property (
        seq_host_read |=> (tx_buf[2] == STATUS_OK) && (tx_buf[3] == OP_READ_IO))
        else $error("read reply status wrong");

    chk_reply_header: assert property (
        seq_reply_start |-> (o_tx_byte == HOST_ADDR) && (tx_cnt == 4'h0))
        else $error("reply header order wrong");

    chk_reply_target: assert property (
        (o_tx_valid && (tx_cnt == 4'h0) && i_tx_ready) |=> (o_tx_byte == MODULE_ADDR))
        else $error("reply target byte wrong");

    chk_digital_bit: assert property (
        (exec_go && cmd.bank == BANK_DIGITAL && cmd.sel <= PORT_LAST_IN)
            |-> (rd_value[31:1] == 31'h0))
        else $error("digital read not one bit");

    chk_port_all: assert property (
        (cmd.bank == BANK_DIGITAL && cmd.sel == PORT_ALL)
            |-> (rd_value == {28'h0, i_gen_in}))
        else $error("all-input read wrong");

    chk_analog_range: assert property (
        (cmd.bank == BANK_ANALOG && cmd.sel == 8'h00) |-> (rd_value < 32'h1000))
        else $error("analog sample out of range");

    chk_arith_load: assert property (
        (seq_prog_op(OP_ARITH) and (i_prog_cmd.sel == AR_LOAD))
            |=> (o_acc == $past(i_prog_cmd.value)))
        else $error("load operand failed");

    chk_compare_flags: assert property (
        seq_prog_op(OP_COMPARE)
            |=> (o_flags.greater == ($past(o_acc) > $past(i_prog_cmd.value))))
        else $error("compare flags wrong");

    chk_cond_ge: assert property (
        (i_cond_sel == CND_GE)
            |=> (o_cond_met == ($past(o_flags.greater) || $past(o_flags.equal))))
        else $error("greater-or-equal test wrong");
endmodule
`default_nettype wire

// *** rtl/ioacc_pkg.sv ***
// Constants and types for the I/O-read and accumulator command block.
// Assumes a single 40 MHz clock domain and nine-byte command frames.
package ioacc_pkg;
    // ****************************************
    // Frame and command codes
    // ****************************************
    localparam logic [7:0] OP_READ_IO     = 8'h0F;
    localparam logic [7:0] OP_ARITH       = 8'h13;
    localparam logic [7:0] OP_COMPARE     = 8'h14;
    localparam logic [7:0] STATUS_OK      = 8'h64;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] MODULE_ADDR    = 8'h01;
    localparam logic [7:0] HOST_ADDR      = 8'h02;
    localparam logic [3:0] LAST_IDX       = 4'h8;
    // ****************************************
    // Banks and ports
    // ****************************************
    localparam logic [7:0] BANK_DIGITAL   = 8'h00;
    localparam logic [7:0] BANK_ANALOG    = 8'h01;
    localparam logic [7:0] BANK_OUTPUTS   = 8'h02;
    localparam logic [7:0] PORT_ALL       = 8'hFF;
    localparam logic [7:0] PORT_SUPPLY    = 8'h08;
    localparam logic [7:0] PORT_LAST_IN   = 8'h03;
    localparam logic [7:0] PORT_LAST_OUT  = 8'h01;
    // ****************************************
    // Arithmetic operations
    // ****************************************
    localparam logic [7:0] AR_ADD  = 8'h00;
    localparam logic [7:0] AR_SUB  = 8'h01;
    localparam logic [7:0] AR_MUL  = 8'h02;
    localparam logic [7:0] AR_DIV  = 8'h03;
    localparam logic [7:0] AR_MODULO = 8'h04;
    localparam logic [7:0] AR_AND  = 8'h05;
    localparam logic [7:0] AR_OR   = 8'h06;
    localparam logic [7:0] AR_XOR  = 8'h07;
    localparam logic [7:0] AR_NOT  = 8'h08;
    localparam logic [7:0] AR_LOAD = 8'h09;
    // ****************************************
    // Jump conditions and reset values
    // ****************************************
    localparam logic [2:0] CND_ZE = 3'h0;
    localparam logic [2:0] CND_NZ = 3'h1;
    localparam logic [2:0] CND_EQ = 3'h2;
    localparam logic [2:0] CND_NE = 3'h3;
    localparam logic [2:0] CND_GT = 3'h4;
    localparam logic [2:0] CND_GE = 3'h5;
    localparam logic [2:0] CND_LT = 3'h6;
    localparam logic [2:0] CND_LE = 3'h7;
    localparam logic [31:0] ACC_RESET = 32'h0;

    typedef struct packed {
        logic [7:0]         opcode;
        logic [7:0]         sel;
        logic [7:0]         bank;
        logic signed [31:0] value;
    } ioacc_cmd_type;

    typedef struct packed {
        logic zero;
        logic equal;
        logic greater;
        logic lower;
    } ioacc_flags_type;
endpackage

// *** verif/ioacc_host.sv ***
// Host model: sends nine-byte command frames and collects reply frames.
// Assumes the device samples on rising edges; the host acts on falling edges.
`timescale 1ns/1ps
`default_nettype none
module ioacc_host (
    input  wire logic       i_clk,
    output var  logic       o_rx_valid,
    output var  logic [7:0] o_rx_byte,
    input  wire logic       i_rx_ready,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_byte,
    output var  logic       o_tx_ready
);
    initial begin
        o_rx_valid = 1'b0;
        o_rx_byte  = 8'h00;
        o_tx_ready = 1'b0;
    end
    // ****************************************
    // Frame transmit, optional bad checksum
    // ****************************************
    task automatic send(input logic [7:0] f [8], input bit bad);
        logic [7:0] b [9];
        int         n;
        int         t;
        b[8] = 8'h00;
        for (int i = 0; i < 8; i++) begin
            b[i] = f[i];
            b[8] = b[8] + f[i];
        end
        b[8] = b[8] ^ {7'h0, bad};
        n = 0;
        t = 0;
        while (n < 9 && t < 200) begin
            @(negedge i_clk);
            t++;
            o_rx_valid = (i_rx_ready === 1'b1);
            if (i_rx_ready === 1'b1) begin
                o_rx_byte = b[n];
                n++;
            end
        end
        @(negedge i_clk);
        o_rx_valid = 1'b0;
        o_rx_byte  = ~o_rx_byte;
    endtask
    // ****************************************
    // Reply receive, prompt or stalling
    // ****************************************
    task automatic recv(input bit slow, output logic [7:0] r [9], output bit ok);
        logic [7:0] s;
        bit         take;
        int         n;
        int         t;
        n = 0;
        t = 0;
        s = 8'h00;
        while (n < 9 && t < 300) begin
            @(negedge i_clk);
            t++;
            take = (i_tx_valid === 1'b1) && (!slow || t[0]);
            o_tx_ready = take;
            if (take) begin
                r[n] = i_tx_byte;
                if (n < 8) s = s + i_tx_byte;
                n++;
            end
        end
        @(negedge i_clk);
        o_tx_ready = 1'b0;
        ok = (n == 9) && (s === r[8]);
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Testbench: host frames and stored instructions with expected results.
// Assumes the host model in ioacc_host and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ioacc_pkg::*;
    logic               clk = 1'b0;
    logic               rstn, rx_valid, rx_ready, tx_valid, tx_ready;
    logic               prog_valid, prog_ack, cond_met;
    logic [7:0]         rx_byte, tx_byte;
    ioacc_cmd_type      prog_cmd;
    logic [3:0]         gen_in;
    logic [11:0]        adc;
    logic [15:0]        supply;
    logic [1:0]         out_state;
    logic [2:0]         cond_sel;
    logic signed [31:0] acc, model;
    ioacc_flags_type    flags;
    int                 err_count, checks_done, cycles;
    logic signed [31:0] opd [10] = '{23, 200, -5000, 7, 300, 32'h6C, 3, 32'hF0, 0, -153};
    logic signed [31:0] cmpv [3] = '{1000, 765000, 2000000};
    logic [3:0]         e;
    always #12.5 clk = ~clk;
    ioacc_core uut (.i_clk(clk), .i_rstn(rstn), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte),
        .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_byte(tx_byte),
        .i_tx_ready(tx_ready), .i_prog_valid(prog_valid), .i_prog_cmd(prog_cmd),
        .o_prog_ack(prog_ack), .i_gen_in(gen_in), .i_adc_in0(adc), .i_supply_dv(supply),
        .i_out_state(out_state), .i_cond_sel(cond_sel), .o_cond_met(cond_met),
        .o_acc(acc), .o_flags(flags));
    ioacc_host host (.i_clk(clk), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte),
        .i_rx_ready(rx_ready), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte),
        .o_tx_ready(tx_ready));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic prog(input logic [7:0] op, sel, bank, input logic [31:0] val);
        int t;
        t = 0;
        @(negedge clk);
        prog_cmd = '{op, sel, bank, val};
        prog_valid = 1'b1;
        do begin
            @(negedge clk);
            t++;
        end while (prog_ack !== 1'b1 && t < 50);
        prog_valid = 1'b0;
        check(32'(t < 50), 32'h1);
    endtask
    task automatic host_cmd(input logic [7:0] op, sel, bank, input logic [31:0] val,
                            input logic [31:0] xv, input bit slow);
        logic [7:0] f [8];
        logic [7:0] r [9];
        logic [7:0] x [9];
        bit         ok;
        f = '{MODULE_ADDR, op, sel, bank, val[31:24], val[23:16], val[15:8], val[7:0]};
        x = '{HOST_ADDR, MODULE_ADDR, STATUS_OK, op, xv[31:24], xv[23:16], xv[15:8], xv[7:0],
              8'h00};
        for (int i = 0; i < 8; i++) x[8] = x[8] + x[i];
        host.send(f, 1'b0);
        host.recv(slow, r, ok);
        check(32'(ok), 32'h1);
        for (int i = 0; i < 9; i++) check(32'(r[i]), 32'(x[i]));
    endtask
    task automatic drop_frame(input logic [7:0] a, input bit bad);
        logic [7:0] f [8];
        bit         seen;
        f = '{a, OP_READ_IO, 8'h00, BANK_ANALOG, 8'h00, 8'h00, 8'h00, 8'h00};
        host.send(f, bad);
        seen = 1'b0;
        repeat (30) begin
            @(negedge clk);
            seen = seen | (tx_valid !== 1'b0);
        end
        check(32'(seen), 32'h0);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            complete_run;
        end
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rstn = 1'b0;
        prog_valid = 1'b0;
        prog_cmd = '0;
        gen_in = 4'hB;
        adc = 12'h12E;
        supply = 16'h00F0;
        out_state = 2'h2;
        cond_sel = 3'h0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        check(acc, 32'h0);
        check(32'(rx_ready), 32'h1);
        check(32'(tx_valid), 32'h0);
        $display("test reset done");
        host_cmd(OP_READ_IO, 8'h00, BANK_ANALOG, 32'h0, 32'h12E, 1'b0);
        for (int p = 0; p < 4; p++) host_cmd(OP_READ_IO, 8'(p), BANK_DIGITAL, 32'h5A5A, 32'(gen_in[p]), p[0]);
        host_cmd(OP_READ_IO, PORT_ALL, BANK_DIGITAL, 32'h0, 32'(gen_in), 1'b1);
        host_cmd(OP_READ_IO, PORT_SUPPLY, BANK_ANALOG, 32'h0, 32'(supply), 1'b0);
        for (int p = 0; p < 2; p++) host_cmd(OP_READ_IO, 8'(p), BANK_OUTPUTS, 32'h0, 32'(out_state[p]), 1'b1);
        check(acc, 32'h0);
        $display("test direct reads done");
        prog(OP_READ_IO, PORT_ALL, BANK_DIGITAL, 32'h0);
        check(acc, 32'(gen_in));
        prog(OP_READ_IO, 8'h00, BANK_ANALOG, 32'h0);
        check(acc, 32'(adc));
        $display("test stored reads done");
        prog(OP_ARITH, AR_LOAD, 8'h00, 32'd100);
        model = 100;
        for (int i = 0; i < 10; i++) begin
            prog(OP_ARITH, 8'(i), 8'h00, opd[i]);
            case (i)
                0: model = model + opd[i];
                1: model = model - opd[i];
                2: model = model * opd[i];
                3: model = model / opd[i];
                4: model = model % opd[i];
                5: model = model & opd[i];
                6: model = model | opd[i];
                7: model = model ^ opd[i];
                8: model = ~model;
                default: model = opd[i];
            endcase
            check(acc, model);
        end
        prog(OP_ARITH, 8'h0A, 8'h00, 32'h7);
        check(acc, model);
        host_cmd(OP_ARITH, AR_MUL, 8'h03, -32'sd5000, -32'sd5000, 1'b1);
        model = model * -5000;
        check(acc, model);
        $display("test arithmetic done");
        for (int k = 0; k < 3; k++) begin
            prog(OP_COMPARE, 8'h55, 8'h07, cmpv[k]);
            e = {model == cmpv[k], model == cmpv[k], model > cmpv[k], model < cmpv[k]};
            check(32'(flags), 32'(e));
            for (int c = 0; c < 8; c++) begin
                @(negedge clk);
                cond_sel = 3'(c);
                repeat (2) @(negedge clk);
                check(32'(cond_met), 32'(c < 2 ? c[0] ^ e[3] : c < 4 ? c[0] ^ e[2] :
                    c < 6 ? e[1] | (c[0] & e[2]) : e[0] | (c[0] & e[2])));
            end
        end
        host_cmd(OP_COMPARE, 8'h00, 8'h00, 32'd1000, 32'd1000, 1'b0);
        $display("test compare done");
        drop_frame(8'h05, 1'b0);
        drop_frame(MODULE_ADDR, 1'b1);
        host_cmd(OP_READ_IO, 8'h00, BANK_OUTPUTS, 32'h0, 32'(out_state[0]), 1'b0);
        $display("test refused frames done");
        complete_run;
    end
endmodule
`default_nettype wire
